//--- verilog/acs_top.sv
`timescale 1ns/1ps
module acs_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [13:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // analog core
  input  wire logic [10:0] core_sample,
  output logic             core_power,
  output logic             core_convert,
  output logic [3:0]       core_channel,
  output logic [1:0]       core_ref_level,
  output logic             core_ref_internal_en,
  output logic             core_ref_to_pin,
  // analog pin gating
  input  wire logic [7:0]  pin_alt_en,
  input  wire logic [7:0]  pin_out_en_in,
  input  wire logic [7:0]  pin_in_raw,
  output logic [7:0]       pin_out_en,
  output logic [7:0]       pin_in
);
  logic        rst_s1_r;
  logic        rst_n_r;
  logic [7:0]  ctrl_0_r;
  logic [7:0]  ctrl_1_r;
  logic [7:0]  result_high_r;
  logic [2:0]  result_low_r;
  logic        valid_r;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        err_r;
  logic        req_w;
  logic        wr_w;
  logic        rd_w;
  logic        hit_c0;
  logic        hit_c1;
  logic        hit_rh;
  logic        hit_rl;
  logic        hit_st;
  logic        mapped_w;
  logic        wr_c0;
  logic        wr_c1;
  logic [7:0]  go_clear_mask;
  acs_ctl_if   ctl ();

  // index of a printed offset from a byte address
  function automatic logic hit(input logic [13:0] adr, input logic [11:0] idx);
    hit = (adr[13:2] == idx);
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // address decode
  assign req_w    = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  assign hit_c0   = hit(wb_adr_i, acs_pkg::ctrl_0_idx);
  assign hit_c1   = hit(wb_adr_i, acs_pkg::ctrl_status_1_idx);
  assign hit_rh   = hit(wb_adr_i, acs_pkg::result_high_idx);
  assign hit_rl   = hit(wb_adr_i, acs_pkg::result_low_idx);
  assign hit_st   = hit(wb_adr_i, acs_pkg::status_idx);
  assign mapped_w = hit_c0 || hit_c1 || hit_rh || hit_rl || hit_st;
  assign wr_w     = req_w && mapped_w && wb_we_i && wb_sel_i[0];
  assign rd_w     = req_w && mapped_w && !wb_we_i;
  assign wr_c0    = wr_w && hit_c0;
  assign wr_c1    = wr_w && hit_c1;

  // read data selection
  always_comb begin
    dat_nxt = '0;
    if (hit_c0) begin
      dat_nxt[7:0] = {ctl.busy, ctrl_0_r[6:0]};
    end else if (hit_c1) begin
      dat_nxt[7:0] = ctrl_1_r;
    end else if (hit_rh) begin
      dat_nxt[7:0] = result_high_r;
    end else if (hit_rl) begin
      dat_nxt[7:0] = {result_low_r, 5'h00};
    end else if (hit_st) begin
      dat_nxt[7:0] = {5'h00, ctl.powered, valid_r, ctl.busy};
    end
  end

  assign ack_nxt = req_w && mapped_w;

  // bus answer one cycle after request
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      err_r <= req_w && !mapped_w;
      if (rd_w) dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = dat_r;

  // go clears at single-shot end, a new write wins
  assign go_clear_mask = (ctl.done && !ctl.repeat_mode) ? 8'h7f : 8'hff;

  // control registers
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_0_r <= acs_pkg::ctrl_0_rst;
      ctrl_1_r <= acs_pkg::ctrl_status_1_rst;
    end else begin
      if (wr_c0) ctrl_0_r <= wb_dat_i[7:0] | {ctrl_0_r[acs_pkg::go_pos] & ctl.busy, 7'h00};
      else       ctrl_0_r <= ctrl_0_r & go_clear_mask;
      if (wr_c1) ctrl_1_r <= wb_dat_i[7:0];
    end
  end

  // result capture and read latching
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result_high_r <= '0;
      result_low_r  <= '0;
      valid_r       <= 1'b0;
    end else begin
      result_high_r <= ctl.sample[10:3];
      if (rd_w && hit_rh) result_low_r <= ctl.sample[2:0];
      if (ctl.done) valid_r <= 1'b1;
      else if (wr_c0 && wb_dat_i[acs_pkg::go_pos] && !wb_dat_i[acs_pkg::repeat_pos]) valid_r <= 1'b0;
    end
  end

  // start pulse and mode to sequencer
  assign ctl.start       = wr_c0 && wb_dat_i[acs_pkg::go_pos];
  assign ctl.repeat_mode = ctrl_0_r[acs_pkg::repeat_pos];

  // analog configuration
  assign core_channel         = ctrl_0_r[3:0];
  assign core_ref_level       = {ctrl_1_r[acs_pkg::hi_pos], ctrl_0_r[acs_pkg::lo_pos]};
  assign core_ref_internal_en = (core_ref_level != acs_pkg::acs_ref_external);
  assign core_ref_to_pin      = ctrl_0_r[acs_pkg::refpin_pos] && core_ref_internal_en;

  acs_sequencer u_seq (
    .clk          (ref_clk),
    .rst_n        (rst_n_r),
    .core_sample  (core_sample),
    .core_power   (core_power),
    .core_convert (core_convert),
    .ctl          (ctl)
  );

  acs_pin_gate u_pins (
    .pin_alt_en    (pin_alt_en),
    .pin_out_en_in (pin_out_en_in),
    .pin_in_raw    (pin_in_raw),
    .pin_out_en    (pin_out_en),
    .pin_in        (pin_in)
  );
endmodule

//--- verilog/acs_pkg.sv
package acs_pkg;
  // register offsets (printed, byte addresses are index * 4)
  localparam logic [11:0] ctrl_0_idx       = 12'hf70;
  localparam logic [11:0] ctrl_status_1_idx = 12'hf71;
  localparam logic [11:0] result_high_idx  = 12'hf72;
  localparam logic [11:0] result_low_idx   = 12'hf73;
  localparam logic [11:0] status_idx       = 12'hf74;
  // reset values
  localparam logic [7:0] ctrl_0_rst        = 8'h00;
  localparam logic [7:0] ctrl_status_1_rst = 8'h80;
  // control register 0 field positions, hi_pos is in control register 1
  localparam int go_pos     = 7;
  localparam int refpin_pos = 6;
  localparam int lo_pos     = 5;
  localparam int repeat_pos = 4;
  localparam int hi_pos     = 7;
  // timing in system clock cycles
  localparam int idle_cycles     = 160;
  localparam int powerup_cycles  = 40;
  localparam int convert_cycles  = 5129;
  localparam int count_w         = 13;
  // reference level decode
  typedef enum logic [1:0] {
    acs_ref_external = 2'b00,
    acs_ref_1v0      = 2'b01,
    acs_ref_2v0      = 2'b10,
    acs_ref_rsvd     = 2'b11
  } acs_ref_type;
  // sequencer states
  typedef enum logic [1:0] {
    acs_off,
    acs_powerup,
    acs_convert,
    acs_idle
  } acs_state_type;
endpackage

//--- verilog/acs_ctl_if.sv
`timescale 1ns/1ps
// control fields and conversion status shared between register file and sequencer
interface acs_ctl_if;
  logic        start;
  logic        repeat_mode;
  logic        busy;
  logic        done;
  logic        powered;
  logic [10:0] sample;
  modport regs (output start, output repeat_mode, input busy, input done, input powered, input sample);
  modport seq  (input start, input repeat_mode, output busy, output done, output powered, output sample);
endinterface

//--- verilog/acs_sequencer.sv
`timescale 1ns/1ps
// powerup, conversion and idle powerdown timing
module acs_sequencer (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // analog core
  input  wire logic [10:0] core_sample,
  output logic        core_power,
  output logic        core_convert,
  // control
  acs_ctl_if.seq      ctl
);
  acs_pkg::acs_state_type state_r;
  acs_pkg::acs_state_type state_nxt;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic [10:0] sample_r;
  logic        done_w;

  // conversion ends at the last cycle of the count
  assign done_w = (state_r == acs_pkg::acs_convert) &&
                  (cnt_r == 13'(acs_pkg::convert_cycles - 1));

  // next state and counter
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 13'h1;
    case (state_r)
      acs_pkg::acs_off: begin
        cnt_nxt = '0;
        if (ctl.start) state_nxt = acs_pkg::acs_powerup;
      end
      acs_pkg::acs_powerup: begin
        if (cnt_r == 13'(acs_pkg::powerup_cycles - 1)) begin
          state_nxt = acs_pkg::acs_convert;
          cnt_nxt   = '0;
        end
      end
      acs_pkg::acs_convert: begin
        if (done_w) begin
          cnt_nxt   = '0;
          state_nxt = ctl.repeat_mode ? acs_pkg::acs_convert : acs_pkg::acs_idle;
        end
      end
      default: begin
        if (ctl.start) begin
          state_nxt = acs_pkg::acs_convert;
          cnt_nxt   = '0;
        end else if (cnt_r == 13'(acs_pkg::idle_cycles - 1)) begin
          state_nxt = acs_pkg::acs_off;
          cnt_nxt   = '0;
        end
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= acs_pkg::acs_off;
      cnt_r    <= '0;
      sample_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (done_w) sample_r <= core_sample;
    end
  end

  assign core_power   = (state_r != acs_pkg::acs_off);
  assign core_convert = (state_r == acs_pkg::acs_convert);
  assign ctl.busy     = (state_r == acs_pkg::acs_powerup) || (state_r == acs_pkg::acs_convert);
  assign ctl.done     = done_w;
  assign ctl.powered  = core_power;
  assign ctl.sample   = sample_r;
endmodule

//--- verilog/acs_pin_gate.sv
`timescale 1ns/1ps
// analog pin alternate function gating
module acs_pin_gate (
  // pin configuration
  input  wire logic [7:0] pin_alt_en,
  input  wire logic [7:0] pin_out_en_in,
  input  wire logic [7:0] pin_in_raw,
  // gated drivers
  output logic [7:0]      pin_out_en,
  output logic [7:0]      pin_in
);
  // analog pins lose digital drivers
  assign pin_out_en = pin_out_en_in & ~pin_alt_en;
  assign pin_in     = pin_in_raw & ~pin_alt_en;
endmodule

//--- tb/acs_core_model.sv
`timescale 1ns/1ps
// analog core stand-in, gives a code set by the channel
module acs_core_model (
  input  wire logic        ref_clk,
  input  wire logic        core_power,
  input  wire logic        core_convert,
  input  wire logic [3:0]  core_channel,
  output logic      [10:0] core_sample
);
  logic [10:0] junk_r = 11'h155;
  // churns outside a conversion so stale codes never match
  always_ff @(posedge ref_clk) begin
    junk_r <= ~junk_r ^ 11'h2a5;
  end
  // negative codes for channels 8 to f
  assign core_sample = (core_power && core_convert) ? {core_channel, 7'h5a} : junk_r;
endmodule

//--- tb/acs_top_properties.sv
`timescale 1ns/1ps
// port-level timing checks
module acs_top_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // bus, core and pins
  input wire logic       wb_ack_o,
  input wire logic       core_power,
  input wire logic       core_convert,
  input wire logic [1:0] core_ref_level,
  input wire logic       core_ref_internal_en,
  input wire logic       core_ref_to_pin,
  input wire logic [7:0] pin_alt_en,
  input wire logic [7:0] pin_out_en,
  input wire logic [7:0] pin_in
);
  logic [12:0] cv_q;
  logic [12:0] id_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // lengths of the convert span and the idle powered span
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cv_q <= 13'h0000;
      id_q <= 13'h0000;
    end else begin
      // wraps per conversion so back-to-back repeat conversions each count 5129
      cv_q <= !core_convert ? 13'h0000 : (cv_q == 13'h1409) ? 13'h0001 : cv_q + 13'h0001;
      id_q <= (core_power && !core_convert) ? id_q + 13'h0001 : 13'h0000;
    end
  end
  conv_length_a: assert property ($fell(core_convert) |-> cv_q == 13'h1409)
    else $error("conversion length wrong");
  idle_limit_a: assert property (id_q <= 13'h00a0)
    else $error("idle too long while powered");
  power_down_a: assert property ($fell(core_power) |-> id_q == 13'h00a0)
    else $error("powerdown at wrong idle count");
  powerup_span_a: assert property ($rose(core_power) |-> ##40 $rose(core_convert))
    else $error("powerup span wrong");
  wake_cause_a: assert property ($rose(core_power) |-> wb_ack_o || $past(wb_ack_o))
    else $error("power rose without request");
  ref_enable_a: assert property (core_ref_internal_en == (core_ref_level != 2'b00))
    else $error("reference enable wrong");
  ref_pin_a: assert property (core_ref_to_pin |-> core_ref_internal_en)
    else $error("reference pin without internal reference");
  pin_gate_a: assert property (((pin_out_en | pin_in) & pin_alt_en) == 8'h00)
    else $error("alternate pin still driven");
  reset_level_a: assert property ($rose(nrst) |-> core_ref_level == 2'b10)
    else $error("reference level reset wrong");
  // main scenarios
  cover property ($fell(core_convert));
  cover property ($rose(core_power));
  cover property ($fell(core_power));
endmodule
bind acs_top acs_top_properties chk_i (.*);

//--- tb/test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
// register, conversion and pin checks
module test_adc_conversion_sequencer;
  typedef struct packed {
    logic [11:0] idx;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic        er;
    logic [1:0]  rl;
  } acs_row_type;
  logic        ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, er;
  logic        core_power, core_convert, core_ref_internal_en, core_ref_to_pin;
  logic [13:0] wb_adr_i;
  logic [3:0]  wb_sel_i, core_channel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [10:0] core_sample;
  logic [1:0]  core_ref_level;
  logic [7:0]  pin_alt_en, pin_out_en_in, pin_in_raw, pin_out_en, pin_in, rd;
  int          fail_count, total_checks, n;
  acs_row_type rows [7] = '{
    '{12'hf71, 8'h55, 8'h55, 1'b0, 2'b00},
    '{12'hf70, 8'h20, 8'h20, 1'b0, 2'b01},
    '{12'hf70, 8'h00, 8'h00, 1'b0, 2'b00},
    '{12'hf71, 8'h80, 8'h80, 1'b0, 2'b10},
    '{12'hf72, 8'hff, 8'h00, 1'b0, 2'b10},
    '{12'hf75, 8'h00, 8'h00, 1'b1, 2'b10},
    '{12'hf70, 8'h4c, 8'h4c, 1'b0, 2'b10}};
  acs_top DUT (.*);
  acs_core_model core (.*);
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic cycle, held until ack or err
  task automatic bus(input logic [11:0] idx, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
    if (k == 50) begin
      fail_count++;
      wrap_up();
    end
    rd = wb_dat_o[7:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  // count edges until power (s=1) or convert reaches v
  task automatic til(input logic s, input logic v, output int c);
    c = 0;
    while ((s ? core_power : core_convert) !== v && c < 6000) begin
      @(posedge ref_clk);
      c++;
    end
    if (c == 6000) begin
      fail_count++;
      wrap_up();
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h1;
    pin_alt_en = 8'h0f;
    pin_out_en_in = 8'hff;
    pin_in_raw = 8'hff;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(core_power, 1'b0);
    bus(12'hf71, 1'b0, 8'h00);
    chk(rd, 8'h80);
    chk(pin_out_en | pin_in, 8'hf0);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(rows[i].idx, 1'b1, rows[i].wd);
      bus(rows[i].idx, 1'b0, 8'h00);
      chk({er, er ? 8'h00 : rd}, {rows[i].er, rows[i].rd});
      chk(core_ref_level, rows[i].rl);
    end
    chk({core_channel, core_ref_to_pin}, 5'h19);
    $display("register table done");
    bus(12'hf70, 1'b1, 8'h8c);
    til(1'b0, 1'b1, n);
    chk(n > 36 && n < 42, 1'b1);
    til(1'b0, 1'b0, n);
    chk(n, 5129);
    bus(12'hf70, 1'b0, 8'h00);
    chk({rd, core_power}, {8'h0c, 1'b1});
    bus(12'hf72, 1'b0, 8'h00);
    chk(rd, 8'hcb);
    bus(12'hf73, 1'b0, 8'h00);
    chk(rd[7:5], 3'b010);
    bus(12'hf74, 1'b0, 8'h00);
    chk(rd, 8'h06);
    bus(12'hf70, 1'b1, 8'h83);
    til(1'b0, 1'b1, n);
    chk(n < 2, 1'b1);
    bus(12'hf70, 1'b0, 8'h00);
    chk(rd[7], 1'b1);
    bus(12'hf70, 1'b1, 8'h93);
    repeat (10258) @(posedge ref_clk);
    chk(core_convert, 1'b1);
    bus(12'hf72, 1'b0, 8'h00);
    chk(rd, 8'h3b);
    bus(12'hf70, 1'b1, 8'h03);
    til(1'b0, 1'b0, n);
    til(1'b1, 1'b0, n);
    chk(n, 160);
    $display("conversion tests done");
    wrap_up();
  end
endmodule
